// ---- core/pcgr_pkg.sv ----
package pcgr_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [31:0] ADDR_FIRST = 32'h4000_b00c;
   localparam logic [31:0] ADDR_SECOND = 32'h4000_b010;
   localparam logic [31:0] ADDR_AON = 32'h4000_f00c;

   localparam logic [31:0] RESET_FIRST = 32'h627f_f9be;
   localparam logic [31:0] RESET_SECOND = 32'h00f8_783f;
   localparam logic [31:0] RESET_AON = 32'h0001_0000;

   // Writable bits; everything else reads as zero.
   localparam logic [31:0] MASK_FIRST = 32'h7fff_f9be;
   localparam logic [31:0] MASK_SECOND = 32'h00ff_ffff;
   localparam logic [31:0] MASK_AON = 32'h003f_c07e;

   // ************************************************************
   // Field positions of the gate and control bits that leave the block
   // ************************************************************
   localparam int FIRST_I2C1_BIT = 29;
   localparam int FIRST_DEC_LSB = 26;
   localparam int FIRST_UART1_LINE_BIT = 16;
   localparam int FIRST_UART1_BUS_BIT = 15;
   localparam int FIRST_UART0_LINE_BIT = 14;
   localparam int FIRST_UART0_BUS_BIT = 13;
   localparam int FIRST_WDOG_LSB = 11;
   localparam int FIRST_TIMER0_BIT = 8;
   localparam int FIRST_PIN_BIT = 7;
   localparam int FIRST_TWIN_BIT = 5;
   localparam int FIRST_SER_LSB = 2;
   localparam int FIRST_FLASH_BIT = 1;
   localparam int SECOND_TIMER0_BUS_BIT = 14;
   localparam int SECOND_PIN_BUS_BIT = 13;
   localparam int SECOND_PHASE_LSB = 11;
   localparam int SECOND_CONV_BIT = 10;
   localparam int SECOND_PULSE_LSB = 6;
   localparam int SECOND_FUSE_LSB = 0;
   localparam int AON_SLEEP_BIT = 16;
   localparam int AON_XO_BYPASS_BIT = 21;
   localparam int AON_CORE_OVR_EN_BIT = 5;

   // ************************************************************
   // Gate vector layout
   // ************************************************************
   localparam int NUM_GATES = 33;
   localparam int G_FLASH = 0;
   localparam int G_SER = 1;
   localparam int G_TWIN = 4;
   localparam int G_PIN = 5;
   localparam int G_TIMER0 = 6;
   localparam int G_WDOG = 7;
   localparam int G_UART0_BUS = 9;
   localparam int G_UART0_LINE = 10;
   localparam int G_UART1_BUS = 11;
   localparam int G_UART1_LINE = 12;
   localparam int G_DEC = 13;
   localparam int G_I2C1 = 16;
   localparam int G_FUSE = 17;
   localparam int G_PULSE = 23;
   localparam int G_CONV = 27;
   localparam int G_PHASE = 28;
   localparam int G_PIN_BUS = 30;
   localparam int G_TIMER0_BUS = 31;
   localparam int G_SLEEP = 32;

   typedef logic [NUM_GATES-1:0] pcgr_gates_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } pcgr_apb_req_t;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } pcgr_apb_rsp_t;

   typedef struct packed {
      logic [31:0] first;
      logic [31:0] second;
      logic [31:0] aon;
      logic [31:0] rdata;
      logic slverr;
   } pcgr_state_t;

endpackage

// ---- core/pcgr_reset_sync.sv ----
`timescale 1ns/1ps
module pcgr_reset_sync (
   input wire logic clock_i,
   input wire logic reset_n_i,
   output logic rst_n_o
);
   logic meta_r;
   logic hold_r;

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_r <= 1'b0;
         hold_r <= 1'b0;
      end else begin
         meta_r <= 1'b1;
         hold_r <= meta_r;
      end
   end

   assign rst_n_o = hold_r;
endmodule

// ---- core/pcgr_clock_gate.sv ----
`timescale 1ns/1ps
module pcgr_clock_gate #(
   parameter bit RESET_ON = 1'b1
) (
   input wire logic src_clk_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   output logic gated_clk_o
);
   logic meta_r;
   logic sync_r;
   logic latch_q;

   // The enable comes from the bus clock, so it is resynchronised first.
   always_ff @(posedge src_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= RESET_ON;
         sync_r <= RESET_ON;
      end else begin
         meta_r <= enable_i;
         sync_r <= meta_r;
      end
   end

   // Transparent only while the source is low, so the gated clock can
   // never lose part of a high phase.
   always_latch begin
      if (!rst_n_i) begin
         latch_q <= RESET_ON;
      end else if (!src_clk_i) begin
         latch_q <= sync_r;
      end
   end

   assign gated_clk_o = src_clk_i & latch_q;
endmodule

// ---- core/pcgr_regs.sv ----
`timescale 1ns/1ps
module pcgr_regs (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire pcgr_pkg::pcgr_apb_req_t apb_req_i,
   output pcgr_pkg::pcgr_apb_rsp_t apb_rsp_o,
   input wire pcgr_pkg::pcgr_gates_t src_clk_i,
   output pcgr_pkg::pcgr_gates_t gated_clk_o,
   output logic [31:0] first_o,
   output logic [31:0] second_o,
   output logic [31:0] aon_o,
   output logic crystal_bypass_force_o,
   output logic core_reset_override_enable_o
);
   import pcgr_pkg::*;

   // ************************************************************
   // Gate mapping
   // ************************************************************
   function automatic pcgr_gates_t gate_map(input logic [31:0] f,
                                            input logic [31:0] s,
                                            input logic [31:0] a);
      pcgr_gates_t g;
      g = '0;
      g[G_FLASH] = f[FIRST_FLASH_BIT];
      g[G_SER +: 3] = f[FIRST_SER_LSB +: 3];
      g[G_TWIN] = f[FIRST_TWIN_BIT];
      g[G_PIN] = f[FIRST_PIN_BIT];
      g[G_TIMER0] = f[FIRST_TIMER0_BIT];
      g[G_WDOG +: 2] = f[FIRST_WDOG_LSB +: 2];
      g[G_UART0_BUS] = f[FIRST_UART0_BUS_BIT];
      g[G_UART0_LINE] = f[FIRST_UART0_LINE_BIT];
      g[G_UART1_BUS] = f[FIRST_UART1_BUS_BIT];
      g[G_UART1_LINE] = f[FIRST_UART1_LINE_BIT];
      g[G_DEC +: 3] = f[FIRST_DEC_LSB +: 3];
      g[G_I2C1] = f[FIRST_I2C1_BIT];
      g[G_FUSE +: 6] = s[SECOND_FUSE_LSB +: 6];
      g[G_PULSE +: 4] = s[SECOND_PULSE_LSB +: 4];
      g[G_CONV] = s[SECOND_CONV_BIT];
      g[G_PHASE +: 2] = s[SECOND_PHASE_LSB +: 2];
      g[G_PIN_BUS] = s[SECOND_PIN_BUS_BIT];
      g[G_TIMER0_BUS] = s[SECOND_TIMER0_BUS_BIT];
      g[G_SLEEP] = a[AON_SLEEP_BIT];
      return g;
   endfunction

   localparam pcgr_gates_t GATE_RESET =
      gate_map(RESET_FIRST, RESET_SECOND, RESET_AON);

   // ************************************************************
   // Reset release
   // ************************************************************
   logic rst_n;

   pcgr_reset_sync u_reset_sync (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .rst_n_o(rst_n)
   );

   // ************************************************************
   // APB slave
   // ************************************************************
   pcgr_state_t st_r;
   pcgr_state_t st_nxt;
   logic [31:0] lane_mask;
   logic setup_phase;
   logic access_phase;
   logic hit_first;
   logic hit_second;
   logic hit_aon;

   assign setup_phase = apb_req_i.psel & ~apb_req_i.penable;
   assign access_phase = apb_req_i.psel & apb_req_i.penable;
   assign hit_first = (apb_req_i.paddr == ADDR_FIRST);
   assign hit_second = (apb_req_i.paddr == ADDR_SECOND);
   assign hit_aon = (apb_req_i.paddr == ADDR_AON);

   always_comb begin
      lane_mask = {{8{apb_req_i.pstrb[3]}}, {8{apb_req_i.pstrb[2]}},
                   {8{apb_req_i.pstrb[1]}}, {8{apb_req_i.pstrb[0]}}};
      st_nxt = st_r;
      // Read data and error are captured in the setup cycle so that the
      // access phase can finish at once with data straight from flops.
      if (setup_phase) begin
         st_nxt.slverr = ~(hit_first | hit_second | hit_aon);
         if (hit_first) begin
            st_nxt.rdata = st_r.first;
         end else if (hit_second) begin
            st_nxt.rdata = st_r.second;
         end else if (hit_aon) begin
            st_nxt.rdata = st_r.aon;
         end else begin
            st_nxt.rdata = '0;
         end
      end
      // Internal bits are stored like any other; keeping them unchanged
      // is left to software.
      if (access_phase && apb_req_i.pwrite) begin
         if (hit_first) begin
            st_nxt.first = (st_r.first & ~(lane_mask & MASK_FIRST)) |
                           (apb_req_i.pwdata & lane_mask & MASK_FIRST);
         end
         if (hit_second) begin
            st_nxt.second = (st_r.second & ~(lane_mask & MASK_SECOND)) |
                            (apb_req_i.pwdata & lane_mask & MASK_SECOND);
         end
         if (hit_aon) begin
            st_nxt.aon = (st_r.aon & ~(lane_mask & MASK_AON)) |
                         (apb_req_i.pwdata & lane_mask & MASK_AON);
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         st_r.first <= RESET_FIRST;
         st_r.second <= RESET_SECOND;
         st_r.aon <= RESET_AON;
         st_r.rdata <= '0;
         st_r.slverr <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_comb begin
      apb_rsp_o.pready = 1'b1;
      apb_rsp_o.prdata = st_r.rdata;
      apb_rsp_o.pslverr = st_r.slverr & access_phase;
   end

   assign first_o = st_r.first;
   assign second_o = st_r.second;
   assign aon_o = st_r.aon;
   assign crystal_bypass_force_o = st_r.aon[AON_XO_BYPASS_BIT];
   assign core_reset_override_enable_o = st_r.aon[AON_CORE_OVR_EN_BIT];

   // ************************************************************
   // Clock gates
   // ************************************************************
   pcgr_gates_t gate_en;

   assign gate_en = gate_map(st_r.first, st_r.second, st_r.aon);

   genvar gi;
   generate
      for (gi = 0; gi < NUM_GATES; gi++) begin : g_gate
         pcgr_clock_gate #(
            .RESET_ON(GATE_RESET[gi])
         ) u_gate (
            .src_clk_i(src_clk_i[gi]),
            .rst_n_i(rst_n),
            .enable_i(gate_en[gi]),
            .gated_clk_o(gated_clk_o[gi])
         );
      end
   endgenerate
endmodule

// ---- tb/pcgr_regs_checker.sv ----
`timescale 1ns/1ps
module pcgr_regs_checker (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire pcgr_pkg::pcgr_apb_req_t apb_req_i,
   input wire pcgr_pkg::pcgr_apb_rsp_t apb_rsp_o,
   input wire pcgr_pkg::pcgr_gates_t src_clk_i,
   input wire pcgr_pkg::pcgr_gates_t gated_clk_o,
   input wire logic [31:0] first_o,
   input wire logic [31:0] second_o,
   input wire logic [31:0] aon_o,
   input wire logic crystal_bypass_force_o,
   input wire logic core_reset_override_enable_o
);
   import pcgr_pkg::*;
   // ****************
   // Checks
   // ****************
   default clocking @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   logic acc;
   logic wr;
   logic hit;
   pcgr_gates_t en;
   assign acc = apb_req_i.psel && apb_req_i.penable;
   assign wr = acc && apb_req_i.pwrite && apb_req_i.pstrb == 4'hf;
   assign hit = apb_req_i.paddr inside {ADDR_FIRST, ADDR_SECOND, ADDR_AON};
   // Enable bits gathered in the order of the gated clock vector.
   assign en = {aon_o[16], second_o[14:0], first_o[29:26], first_o[16:11],
      first_o[8:7], first_o[5:1]};
   a_write_first: assert property (
      wr && apb_req_i.paddr == ADDR_FIRST |=>
      first_o == ($past(apb_req_i.pwdata) & MASK_FIRST))
      else $error("first register write lost");
   a_write_second: assert property (
      wr && apb_req_i.paddr == ADDR_SECOND |=>
      second_o == ($past(apb_req_i.pwdata) & MASK_SECOND))
      else $error("second register write lost");
   a_write_aon: assert property (
      wr && apb_req_i.paddr == ADDR_AON |=>
      aon_o == ($past(apb_req_i.pwdata) & MASK_AON))
      else $error("always-on register write lost");
   a_bad_addr: assert property (
      acc && !hit |-> apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0)
      else $error("unmapped access not refused");
   a_bad_hold: assert property (
      acc && !hit |=> $stable(first_o) && $stable(second_o) && $stable(aon_o))
      else $error("unmapped write changed a register");
   a_read_first: assert property (
      acc && !apb_req_i.pwrite && apb_req_i.paddr == ADDR_FIRST |->
      apb_rsp_o.prdata == first_o)
      else $error("first register read mismatch");
   a_side_outs: assert property (
      crystal_bypass_force_o == aon_o[21] &&
      core_reset_override_enable_o == aon_o[5])
      else $error("internal control outputs differ from storage");
   a_gate_glitch: assert property (
      (gated_clk_o & ~src_clk_i) == '0)
      else $error("gated clock high while source low");
   for (genvar i = 0; i < NUM_GATES; i++) begin : g_gate
      a_gate_follow: assert property (
         $stable(en[i]) [*8] ##1 $stable(en[i]) [*4] |->
         gated_clk_o[i] == (src_clk_i[i] && en[i]))
         else $error("gated clock does not follow its enable");
   end
endmodule
bind pcgr_regs pcgr_regs_checker pcgr_regs_checker_i (
   .clock_i(clock_i), .reset_n_i(reset_n_i), .apb_req_i(apb_req_i),
   .apb_rsp_o(apb_rsp_o), .src_clk_i(src_clk_i), .gated_clk_o(gated_clk_o),
   .first_o(first_o), .second_o(second_o), .aon_o(aon_o),
   .crystal_bypass_force_o(crystal_bypass_force_o),
   .core_reset_override_enable_o(core_reset_override_enable_o));

// ---- tb/pcgr_regs_tb.sv ----
`timescale 1ns/1ps
module pcgr_regs_tb;
   import pcgr_pkg::*;
   // ****************
   // Bench
   // ****************
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   pcgr_apb_req_t req = '0;
   pcgr_apb_rsp_t rsp;
   pcgr_gates_t src = '0;
   pcgr_gates_t gclk;
   logic [31:0] f_o, s_o, a_o, rd;
   logic xb_o, co_o, er;
   int errors = 0;
   int n_tests = 0;
   logic [31:0] ad[3] = '{ADDR_FIRST, ADDR_SECOND, ADDR_AON};
   logic [31:0] mk[3] = '{MASK_FIRST, MASK_SECOND, MASK_AON};
   // Enable bit of each gate: first register 0..31, second 32.., aon 64..
   int gmap[33] = '{1, 2, 3, 4, 5, 7, 8, 11, 12, 13, 14, 15, 16, 26, 27, 28,
      29, 32, 33, 34, 35, 36, 37, 38, 39, 40, 41, 42, 43, 44, 45, 46, 80};
   pcgr_regs pcgr_regs_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .apb_req_i(req), .apb_rsp_o(rsp), .src_clk_i(src),
      .gated_clk_o(gclk), .first_o(f_o), .second_o(s_o), .aon_o(a_o),
      .crystal_bypass_force_o(xb_o), .core_reset_override_enable_o(co_o));
   always #5 clock_i = ~clock_i;
   always @(posedge clock_i) src <= ~src;
   task check(input logic [32:0] seen, input logic [32:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge clock_i);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d,
         pstrb: s};
      @(posedge clock_i);
      req.penable <= 1'b1;
      do @(posedge clock_i); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task close_out;
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task t_reset_vals;
      apb(1'b0, ADDR_FIRST, 32'h0, 4'hf);
      check({er, rd}, {1'b0, 32'h627f_f9be});
      check(f_o, 32'h627f_f9be);
      apb(1'b0, ADDR_SECOND, 32'h0, 4'hf);
      check(rd, 32'h00f8_783f);
      apb(1'b0, ADDR_AON, 32'h0, 4'hf);
      check(rd, 32'h0001_0000);
   endtask
   task t_storage;
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, ad[i], 32'hffff_ffff, 4'hf);
         apb(1'b0, ad[i], 32'h0, 4'hf);
         check(rd, mk[i]);
      end
      check({xb_o, co_o}, 2'b11);
      check(f_o, MASK_FIRST);
      check(a_o, MASK_AON);
      // Only byte lane zero may change.
      apb(1'b1, ADDR_SECOND, 32'h0, 4'h1);
      apb(1'b0, ADDR_SECOND, 32'h0, 4'hf);
      check(rd, 32'h00ff_ff00);
   endtask
   task t_unmapped;
      apb(1'b1, 32'h4000_b014, 32'h0, 4'hf);
      check({er, rd}, {1'b1, 32'h0});
      apb(1'b0, ADDR_SECOND, 32'h0, 4'hf);
      check(rd, 32'h00ff_ff00);
      check(s_o, 32'h00ff_ff00);
   endtask
   task t_gates;
      logic [31:0] v[3];
      pcgr_gates_t s;
      pcgr_gates_t x;
      for (int g = 0; g < 33; g++) begin
         v = '{default: 32'h0};
         v[gmap[g] / 32][gmap[g] % 32] = 1'b1;
         for (int i = 0; i < 3; i++) apb(1'b1, ad[i], v[i], 4'hf);
         repeat (14) @(posedge clock_i);
         s = '0;
         x = 33'h1 << g;
         repeat (8) @(negedge clock_i) s |= gclk;
         check(s[6:0], x[6:0]);
         check(s[12:7], x[12:7]);
         check(s[22:13], x[22:13]);
         check(s[31:23], x[31:23]);
         check(s[32], x[32]);
      end
   endtask
   initial begin
      repeat (16) @(posedge clock_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      t_reset_vals;
      t_storage;
      t_unmapped;
      t_gates;
      close_out;
   end
   initial begin
      #50000;
      errors++;
      close_out;
   end
endmodule
